// file: rtl/eeic_pkg.sv
// Package for the external edge interrupt control block.
// Holds register offsets, field layout, reset values and the carrier types.
// Assumes a 16-bit word-addressed register port on the system clock.
package eeic_pkg;

   // Bus and counter widths, and the number of lines
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int CNT_W = 16;
   localparam int NUM_LINES = 3;

   // Line indices: two maskable lines and the line shared with the NMI
   localparam int LINE_ONE = 0;
   localparam int LINE_TWO = 1;
   localparam int LINE_L13 = 2;

   // Register word offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL1 = 16'h7070;
   localparam logic [ADDR_W-1:0] OFF_CTRL2 = 16'h7071;
   localparam logic [ADDR_W-1:0] OFF_NMICTRL = 16'h7077;
   localparam logic [ADDR_W-1:0] OFF_CNT1 = 16'h7078;
   localparam logic [ADDR_W-1:0] OFF_CNT2 = 16'h7079;
   localparam logic [ADDR_W-1:0] OFF_CNTNMI = 16'h707F;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 16'h7080;
   localparam logic [ADDR_W-1:0] OFF_MASK = 16'h7081;

   // Control field positions
   localparam int POL_LSB = 2;
   localparam int POL_MSB = 3;
   localparam int SEL_BIT = 1;
   localparam int EN_BIT = 0;

   // Polarity codes; any other code means falling edge
   localparam logic [1:0] POL_RISE = 2'h1;
   localparam logic [1:0] POL_BOTH = 2'h3;

   // Writable bits of each control register
   localparam logic [DATA_W-1:0] CTRL_WMASK = 16'h000D;
   localparam logic [DATA_W-1:0] NMICTRL_WMASK = 16'h000F;

   // Reset values
   localparam logic [1:0] POL_RST = 2'h0;
   localparam logic SEL_RST = 1'b0;
   localparam logic EN_RST = 1'b0;
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [NUM_LINES-1:0] STATUS_RST = 3'h0;
   localparam logic [NUM_LINES-1:0] MASK_RST = 3'h0;
   localparam logic [DATA_W-1:0] RDATA_RST = 16'h0000;

   // Per-line control as held in the registers
   typedef struct packed {
      logic [1:0] polarity;
      logic sel;
      logic enable;
   } eeic_ctrl_s;

   // One register port request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } eeic_bus_req_s;

endpackage : eeic_pkg

// file: rtl/eeic_edge_detect.sv
// Pin synchroniser and edge qualifier for one external interrupt line.
// Assumes the pin is asynchronous to clk; control comes from clk registers.
`timescale 1ns/10ps
module eeic_edge_detect
   import eeic_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic pinIn,
   input wire eeic_ctrl_s ctrl,
   output logic edgeValid
);

   logic sync1_r;
   logic sync2_r;
   logic prev_r;
   logic rise;
   logic fall;

   // Two-stage synchroniser, then one more stage to compare samples
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         sync1_r <= pinIn;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end

   // Successive settled samples give the direction of the transition
   assign rise = sync2_r & ~prev_r;
   assign fall = ~sync2_r & prev_r;

   // Polarity picks the edge; a disabled line never qualifies one
   always_comb begin
      unique case (ctrl.polarity)
         POL_RISE: edgeValid = rise;
         POL_BOTH: edgeValid = rise | fall;
         default: edgeValid = fall;
      endcase
      edgeValid = edgeValid & ctrl.enable;
   end

endmodule : eeic_edge_detect

// file: rtl/eeic_top.sv
// External edge interrupt controller: register port, three edge lines,
// timestamp counters, level-13 source select and an event interrupt.
// Summary of operation
// - Three external interrupt lines: one, two, and one feeding CPU level 13.
// - The level-13 line shares its pin with the non-maskable interrupt.
// - Every line, the NMI included, has its own edge select and enable.
// - Each line has a 16-bit up-counter cleared on every valid edge.
// - Polarity bits 3-2: 00/10 falling, 01 rising, 11 both edges.
// - Bit 0 of line one control blocks (0) or passes (1) its requests.
// - Line two has its own control register with identical fields.
// - Control bits 15-4, and bit 1 on lines one and two, read zero; writes to them ignored.
// - NMI control select bit: 0 timer drives level 13, 1 the shared pin.
// - Counters run at clock rate, wrap at maximum, and are read-only.
// - A counter halts while disabled; only valid edge or reset clears it.
// Assumes pins are asynchronous and the timer request comes from clk logic.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
module eeic_top
   import eeic_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire eeic_bus_req_s busReq,
   output logic [DATA_W-1:0] rdData,
   input wire logic extIrqLineOne,
   input wire logic extIrqLineTwo,
   input wire logic extIrqLineLevel13,
   input wire logic timerIrq,
   output logic cpuIrqLineOne,
   output logic cpuIrqLineTwo,
   output logic cpuIrqLevel13,
   output logic cpuNmi,
   output logic irqOut
);

   // Control registers, one per line; the level-13 entry is the NMI control
   eeic_ctrl_s ctrl_r [NUM_LINES];
   logic [CNT_W-1:0] cnt_r [NUM_LINES];
   logic [NUM_LINES-1:0] pins;
   logic [NUM_LINES-1:0] edgeValid;
   logic [NUM_LINES-1:0] status_r;
   logic [NUM_LINES-1:0] status_nxt;
   logic [NUM_LINES-1:0] mask_r;
   logic [DATA_W-1:0] rdData_r;
   logic [DATA_W-1:0] rdData_nxt;
   logic cpuIrqLineOne_r;
   logic cpuIrqLineTwo_r;
   logic cpuIrqLevel13_r;
   logic cpuNmi_r;
   logic wrCtrl [NUM_LINES];
   logic stsRead;

   // Pin vector in line order; level 13 pin also serves the NMI
   assign pins = {extIrqLineLevel13, extIrqLineTwo, extIrqLineOne};

   // Write decode for the three control registers
   always_comb begin
      wrCtrl[LINE_ONE] = busReq.wr && (busReq.addr == OFF_CTRL1);
      wrCtrl[LINE_TWO] = busReq.wr && (busReq.addr == OFF_CTRL2);
      wrCtrl[LINE_L13] = busReq.wr && (busReq.addr == OFF_NMICTRL);
   end

   // A status read clears the events it returns
   assign stsRead = busReq.rd && (busReq.addr == OFF_STATUS);

   // Per-line logic: control register, edge detector and timestamp counter
   for (genvar i = 0; i < NUM_LINES; i++) begin : g_line

      // Polarity and enable are writable on every line; the select bit exists on the
      // NMI control alone, so the other lines keep it at zero
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            ctrl_r[i] <= '{polarity: POL_RST, sel: SEL_RST, enable: EN_RST};
         end else if (wrCtrl[i]) begin
            ctrl_r[i].polarity <= busReq.wdata[POL_MSB:POL_LSB];
            ctrl_r[i].enable <= busReq.wdata[EN_BIT];
            if (i == LINE_L13) begin
               ctrl_r[i].sel <= busReq.wdata[SEL_BIT];
            end else begin
               ctrl_r[i].sel <= SEL_RST;
            end
         end
      end

      // Synchronise the pin and qualify the edge against this line's control
      eeic_edge_detect u_edge (
         .clk(clk),
         .rstn(rstn),
         .pinIn(pins[i]),
         .ctrl(ctrl_r[i]),
         .edgeValid(edgeValid[i])
      );

      // Timestamp: clear on a valid edge, count while enabled, hold when
      // disabled; natural 16-bit overflow gives the wrap to zero
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            cnt_r[i] <= CNT_RST;
         end else if (edgeValid[i]) begin
            cnt_r[i] <= CNT_RST;
         end else if (ctrl_r[i].enable) begin
            cnt_r[i] <= cnt_r[i] + 16'h0001;
         end
      end
   end

   // Requests to the CPU, one clock per qualified edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cpuIrqLineOne_r <= 1'b0;
         cpuIrqLineTwo_r <= 1'b0;
      end else begin
         cpuIrqLineOne_r <= edgeValid[LINE_ONE];
         cpuIrqLineTwo_r <= edgeValid[LINE_TWO];
      end
   end

   // Shared pin: select routes its edge to level 13, otherwise to the NMI,
   // and the timer owns level 13 while select is clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cpuIrqLevel13_r <= 1'b0;
         cpuNmi_r <= 1'b0;
      end else if (ctrl_r[LINE_L13].sel) begin
         cpuIrqLevel13_r <= edgeValid[LINE_L13];
         cpuNmi_r <= 1'b0;
      end else begin
         cpuIrqLevel13_r <= timerIrq;
         cpuNmi_r <= edgeValid[LINE_L13];
      end
   end

   assign cpuIrqLineOne = cpuIrqLineOne_r;
   assign cpuIrqLineTwo = cpuIrqLineTwo_r;
   assign cpuIrqLevel13 = cpuIrqLevel13_r;
   assign cpuNmi = cpuNmi_r;

   // Sticky events; a new edge in the read cycle survives the clear
   always_comb begin
      status_nxt = status_r;
      if (stsRead) begin
         status_nxt = STATUS_RST;
      end
      status_nxt = status_nxt | edgeValid;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         status_r <= STATUS_RST;
      end else begin
         status_r <= status_nxt;
      end
   end

   // Event mask, same bit layout as the status register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mask_r <= MASK_RST;
      end else if (busReq.wr && (busReq.addr == OFF_MASK)) begin
         mask_r <= busReq.wdata[NUM_LINES-1:0];
      end
   end

   // Level interrupt; combinational from registers so it drops with the read
   assign irqOut = |(status_r & mask_r);

   // Read mux: reserved and unmapped bits return zero; counters have no
   // write path at all, so software can never disturb a timestamp
   always_comb begin
      rdData_nxt = RDATA_RST;
      if (busReq.rd) begin
         unique case (busReq.addr)
            OFF_CTRL1: rdData_nxt = 16'(ctrl_r[LINE_ONE]) & CTRL_WMASK;
            OFF_CTRL2: rdData_nxt = 16'(ctrl_r[LINE_TWO]) & CTRL_WMASK;
            OFF_NMICTRL: rdData_nxt = 16'(ctrl_r[LINE_L13]) & NMICTRL_WMASK;
            OFF_CNT1: rdData_nxt = cnt_r[LINE_ONE];
            OFF_CNT2: rdData_nxt = cnt_r[LINE_TWO];
            OFF_CNTNMI: rdData_nxt = cnt_r[LINE_L13];
            OFF_STATUS: rdData_nxt = {{(DATA_W-NUM_LINES){1'b0}}, status_r};
            OFF_MASK: rdData_nxt = {{(DATA_W-NUM_LINES){1'b0}}, mask_r};
            default: rdData_nxt = RDATA_RST;
         endcase
      end
   end

   // Read data stand for exactly the cycle after the strobe
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdData_r <= RDATA_RST;
      end else begin
         rdData_r <= rdData_nxt;
      end
   end

   assign rdData = rdData_r;

endmodule : eeic_top

// file: sim/eeic_monitor.sv
// Port-level checker for the edge interrupt block.
// Assumes it is bound to eeic_top and sees only that module's ports.
`timescale 1ns/10ps
module eeic_monitor
   import eeic_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire eeic_bus_req_s busReq,
   input wire logic [DATA_W-1:0] rdData,
   input wire logic extIrqLineOne,
   input wire logic extIrqLineTwo,
   input wire logic extIrqLineLevel13,
   input wire logic timerIrq,
   input wire logic cpuIrqLineOne,
   input wire logic cpuIrqLineTwo,
   input wire logic cpuIrqLevel13,
   input wire logic cpuNmi,
   input wire logic irqOut
);
   logic [2:0] hist_r [4];
   logic [2:0] pinChg;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Pin history; one cycle of slack so sampling phase cannot cause false fails
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hist_r <= '{default: 3'h0};
      end else begin
         hist_r <= '{{extIrqLineLevel13, extIrqLineTwo, extIrqLineOne},
            hist_r[0], hist_r[1], hist_r[2]};
      end
   end
   assign pinChg = (hist_r[1] ^ hist_r[2]) | (hist_r[2] ^ hist_r[3]);
   AST_RD_IDLE: assert property (!$past(busReq.rd) |-> rdData == 16'h0000)
      else $error("read data outside read slot");
   AST_ONE_PULSE: assert property (cpuIrqLineOne |=> !cpuIrqLineOne)
      else $error("line one request longer than one cycle");
   AST_EDGE_ONE: assert property (cpuIrqLineOne |-> pinChg[0])
      else $error("line one request without pin edge");
   AST_EDGE_TWO: assert property (cpuIrqLineTwo |-> pinChg[1])
      else $error("line two request without pin edge");
   AST_EDGE_L13: assert property (cpuIrqLevel13 && !$past(timerIrq) |-> pinChg[2])
      else $error("level 13 request without source");
   AST_NMI_SRC: assert property (cpuNmi |-> pinChg[2] && !(cpuIrqLevel13 && !$past(timerIrq)))
      else $error("nmi request wrong");
   AST_IRQ_RISE: assert property ($rose(irqOut) |->
      (cpuIrqLineOne || cpuIrqLineTwo || cpuIrqLevel13 || cpuNmi || $past(busReq.wr)))
      else $error("interrupt rose without event");
   AST_IRQ_FALL: assert property ($fell(irqOut) |-> $past(busReq.rd) || $past(busReq.wr))
      else $error("interrupt fell without access");
endmodule : eeic_monitor

bind eeic_top eeic_monitor u_mon (.clk, .rstn, .busReq, .rdData, .extIrqLineOne,
   .extIrqLineTwo, .extIrqLineLevel13, .timerIrq, .cpuIrqLineOne, .cpuIrqLineTwo,
   .cpuIrqLevel13, .cpuNmi, .irqOut);

// file: sim/eeic_pin_model.sv
// Model of the external pins and the timer request source.
// Assumes the bench sets wanted levels; pins follow one edge later.
`timescale 1ns/10ps
module eeic_pin_model (
   input wire logic clk,
   input wire logic [3:0] want,
   output logic [3:0] pins = 4'h0
);
   // Pins move after an edge, as a slow external driver would
   always @(posedge clk) begin
      pins <= want;
   end
endmodule : eeic_pin_model

// file: sim/test_external_edge_interrupt_control.sv
// Bench: register tasks and edge scenarios for each line.
// Assumes eeic_top, its checker bind and the pin model are compiled.
`timescale 1ns/10ps
`define CHK(n, e, s) begin samplesChecked++; if ((s) !== (e)) begin errors++; \
   $display("Error %s exp %h got %h", n, e, s); end end
module test_external_edge_interrupt_control import eeic_pkg::*;;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   eeic_bus_req_s busReq = '0;
   logic [DATA_W-1:0] rdData;
   logic [3:0] want = 4'h0;
   logic [3:0] pins;
   logic [3:0] outs;
   logic irqOut;
   logic [15:0] v;
   logic [15:0] ctrlOff [3] = '{OFF_CTRL1, OFF_CTRL2, OFF_NMICTRL};
   logic [15:0] cntOff [3] = '{OFF_CNT1, OFF_CNT2, OFF_CNTNMI};
   int pulseCnt [4] = '{default: 0};
   int errors = 0;
   int samplesChecked = 0;
   int b;
   int b2;
   int x;
   always #10 clk = ~clk;
   eeic_pin_model pm (.clk, .want, .pins);
   eeic_top dut (.clk, .rstn, .busReq, .rdData, .extIrqLineOne(pins[0]),
      .extIrqLineTwo(pins[1]), .extIrqLineLevel13(pins[2]), .timerIrq(pins[3]),
      .cpuIrqLineOne(outs[0]), .cpuIrqLineTwo(outs[1]), .cpuIrqLevel13(outs[2]),
      .cpuNmi(outs[3]), .irqOut);
   // Count request pulses per output
   always @(posedge clk) begin
      for (int k = 0; k < 4; k++) begin
         pulseCnt[k] += int'(outs[k] === 1'b1);
      end
   end
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      busReq.wr <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge clk);
      busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      busReq.rd <= 1'b0;
      #1 d = rdData;
   endtask : rd
   task automatic rdc(input logic [15:0] a, input logic [15:0] e);
      logic [15:0] d;
      rd(a, d);
      `CHK("register read", e, d)
   endtask : rdc
   // Pins held six cycles, well over the two-cycle minimum
   task automatic edges(input int l);
      @(posedge clk);
      want[l] <= 1'b1;
      repeat (6) @(posedge clk);
      want[l] <= 1'b0;
      repeat (6) @(posedge clk);
   endtask : edges
   task automatic finish_test;
      if (errors == 0 && samplesChecked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : finish_test
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      finish_test();
   end
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      foreach (ctrlOff[i]) rdc(ctrlOff[i], 16'h0000);
      rdc(OFF_STATUS, 16'h0000);
      foreach (ctrlOff[i]) wr(ctrlOff[i], 16'hFFFF);
      rdc(OFF_CTRL1, 16'h000D);
      rdc(OFF_CTRL2, 16'h000D);
      rdc(OFF_NMICTRL, 16'h000F);
      wr(16'h7072, 16'h1234);
      rdc(16'h7072, 16'h0000);
      // Counter ignores writes and advances one per clock
      wr(OFF_CNT1, 16'hFFFF);
      rd(OFF_CNT1, v);
      `CHK("counter write", 1'b1, v < 16'h0040)
      rdc(OFF_CNT1, v + 16'h0002);
      wr(OFF_CTRL2, 16'h0000);
      rd(OFF_CNT2, v);
      rdc(OFF_CNT2, v);
      // Every polarity code on every line, then a disabled line
      wr(OFF_MASK, 16'h0007);
      for (int l = 0; l < 3; l++) begin
         for (int p = 0; p < 5; p++) begin
            x = (l == 2) ? 3 : l;
            wr(ctrlOff[l], (p < 4) ? {12'h000, 2'(p), 2'b01} : 16'h000C);
            b = pulseCnt[x];
            edges(l);
            `CHK("pulses", (p < 4) ? int'(p == 1 || p == 3) + int'(p != 1) : 0, pulseCnt[x] - b)
            rd(cntOff[l], v);
            `CHK("timestamp", 1'b1, p == 4 || v < 16'h0020)
         end
      end
      `CHK("irqOut", 1'b1, irqOut)
      rdc(OFF_STATUS, 16'h0007);
      `CHK("irqOut", 1'b0, irqOut)
      // Masked events, shared pin to level 13, then timer to level 13
      wr(OFF_MASK, 16'h0000);
      wr(OFF_NMICTRL, 16'h0007);
      b = pulseCnt[2];
      b2 = pulseCnt[3];
      edges(2);
      `CHK("level13 pin", 1, pulseCnt[2] - b)
      `CHK("nmi off", 0, pulseCnt[3] - b2)
      wr(OFF_NMICTRL, 16'h0001);
      b = pulseCnt[2];
      want[3] <= 1'b1;
      @(posedge clk);
      want[3] <= 1'b0;
      repeat (4) @(posedge clk);
      `CHK("level13 timer", 1, pulseCnt[2] - b)
      wr(OFF_CTRL1, 16'h0005);
      edges(0);
      `CHK("irqOut masked", 1'b0, irqOut)
      rdc(OFF_STATUS, 16'h0005);
      finish_test();
   end
endmodule : test_external_edge_interrupt_control
